// >>> hdl/pdem_mux.sv
// Port D upper nibble, port E and ready input alternate function multiplexer
// Summary of operation
// - Port D 4..7 are GPIO or data 12..15
// - Each port E pin selects alternate by bit
// - Timer 0/1 overflow pulses one clock
// - Split mode pulses on low byte overflow
// - Timer 2 overflow pulses one clock
// - UART0 pin: sync data mode 0, else 1
// - UART1 pin: sync data mode 0, else high
// - Interrupt six pin is rising edge sensitive
// - Timer 2 reload on falling edge, if enabled
// - Pin E7 outputs waveform address bit 8
// - Ready 0 or read strobe, polarity bit 3
// - Ready 1 or write strobe, polarity bit 2
// - Ready 2 only a waveform ready input
`timescale 1ns/100ps
module pdem_mux (
  input wire logic clk,
  input wire logic rst_n,
  // Configuration
  input wire logic [1:0] interfaceConfigMode,
  input wire logic endpointWordWide,
  input wire logic [7:0] porteAltSelect,
  input wire logic [3:0] fifoPinPolarity,
  input wire logic timer2ExtEnable,
  // Port D GPIO side and data bus side
  input wire logic [3:0] portdOut,
  input wire logic [3:0] portdOe,
  input wire logic [3:0] ifaceDataOut,
  input wire logic [3:0] ifaceDataOe,
  // Port D pins (enable low drives)
  input wire logic [3:0] portdPinIn,
  output logic [3:0] portdPinOut,
  output logic [3:0] portdPinOe_n,
  output logic [3:0] portdIn,
  output logic [3:0] ifaceDataIn,
  // Port E GPIO side
  input wire logic [7:0] porteOut,
  input wire logic [7:0] porteOe,
  input wire logic [7:0] portePinIn,
  output logic [7:0] portePinOut,
  output logic [7:0] portePinOe_n,
  output logic [7:0] porteIn,
  // Core sources
  input wire pdem_pkg::pdem_timer_ev_t timerEv,
  input wire pdem_pkg::pdem_uart_t uart0,
  input wire pdem_pkg::pdem_uart_t uart1,
  input wire logic waveformAddrBit8,
  // Core sinks
  output logic extInterruptSix,
  output logic timer2Reload,
  // Ready and strobe pins
  input wire logic readyIn0,
  input wire logic readyIn1,
  input wire logic readyIn2,
  output logic [2:0] waveReady,
  output logic slaveReadStrobe,
  output logic slaveWriteStrobe
);

  logic [7:0] peSync; // Synchronised port E pins
  logic [3:0] pdSync; // Synchronised port D pins
  logic [2:0] rdySync; // Synchronised ready pins
  logic extIntPrev_q; // Previous interrupt pin level
  logic reloadPrev_q; // Previous reload pin level
  logic dataSel; // Port D used as upper data
  pdem_pkg::pdem_rdy_mode_t rdyMode; // Ready pin role

  // One synchroniser per pin input
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_pe
      pdem_sync u_sync (.clk(clk), .rst_n(rst_n), .pinIn(portePinIn[gi]), .levelOut(peSync[gi]));
    end
    for (gi = 0; gi < 4; gi++) begin : g_pd
      pdem_sync u_sync (.clk(clk), .rst_n(rst_n), .pinIn(portdPinIn[gi]), .levelOut(pdSync[gi]));
    end
  endgenerate
  pdem_sync u_readySync0 (.clk(clk), .rst_n(rst_n), .pinIn(readyIn0), .levelOut(rdySync[0]));
  pdem_sync u_readySync1 (.clk(clk), .rst_n(rst_n), .pinIn(readyIn1), .levelOut(rdySync[1]));
  pdem_sync u_readySync2 (.clk(clk), .rst_n(rst_n), .pinIn(readyIn2), .levelOut(rdySync[2]));

  // Data bus needs a controller mode plus word-wide endpoint
  function automatic logic isBusMode(input logic [1:0] m);
    isBusMode = (m == pdem_pkg::IFMODE_WAVE) || (m == pdem_pkg::IFMODE_SLAVE);
  endfunction : isBusMode

  assign dataSel = isBusMode(interfaceConfigMode) && endpointWordWide;

  // Ready pins role from interface mode
  always_comb begin
    if (interfaceConfigMode == pdem_pkg::IFMODE_SLAVE) begin
      rdyMode = pdem_pkg::PDEM_RDY_SLAVE;
    end else if (interfaceConfigMode == pdem_pkg::IFMODE_WAVE) begin
      rdyMode = pdem_pkg::PDEM_RDY_WAVE;
    end else begin
      rdyMode = pdem_pkg::PDEM_RDY_IDLE;
    end
  end

  // Port D pin drive; idle reset state is released (input)
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      portdPinOut <= 4'h0;
      portdPinOe_n <= 4'hf;
    end else if (dataSel) begin
      portdPinOut <= ifaceDataOut;
      portdPinOe_n <= ~ifaceDataOe;
    end else begin
      portdPinOut <= portdOut;
      portdPinOe_n <= ~portdOe;
    end
  end

  // Port D input routing; the unused side reads zero
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      portdIn <= 4'h0;
      ifaceDataIn <= 4'h0;
    end else begin
      portdIn <= dataSel ? 4'h0 : pdSync;
      ifaceDataIn <= dataSel ? pdSync : 4'h0;
    end
  end

  // Port E output drive per pin
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      portePinOut <= 8'h00;
      portePinOe_n <= 8'hff;
    end else begin
      for (int i = 0; i < 8; i++) begin
        portePinOut[i] <= porteOut[i];
        portePinOe_n[i] <= ~porteOe[i];
      end
      // Output alternates drive the pin; input alternates release it
      if (porteAltSelect[pdem_pkg::PE_T0]) begin
        // Split mode pulses come from the low byte counter only
        portePinOut[pdem_pkg::PE_T0] <= timerEv.t0Ovf;
        portePinOe_n[pdem_pkg::PE_T0] <= 1'b0;
      end
      if (porteAltSelect[pdem_pkg::PE_T1]) begin
        portePinOut[pdem_pkg::PE_T1] <= timerEv.t1Ovf;
        portePinOe_n[pdem_pkg::PE_T1] <= 1'b0;
      end
      if (porteAltSelect[pdem_pkg::PE_T2]) begin
        portePinOut[pdem_pkg::PE_T2] <= timerEv.t2Ovf;
        portePinOe_n[pdem_pkg::PE_T2] <= 1'b0;
      end
      if (porteAltSelect[pdem_pkg::PE_U0]) begin
        // Idle high keeps the far receiver quiet outside sync mode
        portePinOut[pdem_pkg::PE_U0] <= (uart0.mode == pdem_pkg::UART_MODE_SYNC) ? uart0.syncData : 1'b1;
        portePinOe_n[pdem_pkg::PE_U0] <= 1'b0;
      end
      if (porteAltSelect[pdem_pkg::PE_U1]) begin
        portePinOut[pdem_pkg::PE_U1] <= (uart1.mode == pdem_pkg::UART_MODE_SYNC) ? uart1.syncData : 1'b1;
        portePinOe_n[pdem_pkg::PE_U1] <= 1'b0;
      end
      if (porteAltSelect[pdem_pkg::PE_EXTINT]) begin
        portePinOe_n[pdem_pkg::PE_EXTINT] <= 1'b1;
      end
      if (porteAltSelect[pdem_pkg::PE_RELOAD]) begin
        portePinOe_n[pdem_pkg::PE_RELOAD] <= 1'b1;
      end
      if (porteAltSelect[pdem_pkg::PE_ADR8]) begin
        portePinOut[pdem_pkg::PE_ADR8] <= waveformAddrBit8;
        portePinOe_n[pdem_pkg::PE_ADR8] <= 1'b0;
      end
    end
  end

  // GPIO input view of port E; alternate pins read zero
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      porteIn <= 8'h00;
    end else begin
      porteIn <= peSync & ~porteAltSelect;
    end
  end

  // Edge detection for the interrupt and reload inputs
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      // Low matches the synchroniser's reset output, so no false edge
      extIntPrev_q <= 1'b0;
      reloadPrev_q <= 1'b0;
      extInterruptSix <= 1'b0;
      timer2Reload <= 1'b0;
    end else begin
      extIntPrev_q <= peSync[pdem_pkg::PE_EXTINT];
      reloadPrev_q <= peSync[pdem_pkg::PE_RELOAD];
      extInterruptSix <= porteAltSelect[pdem_pkg::PE_EXTINT] && peSync[pdem_pkg::PE_EXTINT] && !extIntPrev_q;
      timer2Reload <= porteAltSelect[pdem_pkg::PE_RELOAD] && timer2ExtEnable
                      && !peSync[pdem_pkg::PE_RELOAD] && reloadPrev_q;
    end
  end

  // Ready and strobe routing; strobes are normalised to active high
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      waveReady <= 3'h0;
      slaveReadStrobe <= 1'b0;
      slaveWriteStrobe <= 1'b0;
    end else begin
      // Ready 2 has no alternate role
      waveReady[2] <= rdySync[2];
      waveReady[1:0] <= (rdyMode == pdem_pkg::PDEM_RDY_WAVE) ? rdySync[1:0] : 2'h0;
      // Master is trusted to drive one strobe at this polarity
      slaveReadStrobe <= (rdyMode == pdem_pkg::PDEM_RDY_SLAVE)
                         && (rdySync[0] ~^ fifoPinPolarity[pdem_pkg::POL_RD]);
      slaveWriteStrobe <= (rdyMode == pdem_pkg::PDEM_RDY_SLAVE)
                          && (rdySync[1] ~^ fifoPinPolarity[pdem_pkg::POL_WR]);
    end
  end

  // Assertions
  AST_T2_PULSE: assert property (@(posedge clk) disable iff (!rst_n)
    porteAltSelect[pdem_pkg::PE_T2] && timerEv.t2Ovf |=> portePinOut[pdem_pkg::PE_T2] && !portePinOe_n[pdem_pkg::PE_T2])
    else $error("timer 2 overflow not on pin");
  AST_T0_PULSE: assert property (@(posedge clk) disable iff (!rst_n)
    porteAltSelect[pdem_pkg::PE_T0] && $stable(porteAltSelect) && !timerEv.t0Ovf |=> !portePinOut[pdem_pkg::PE_T0])
    else $error("timer 0 pin high without overflow");
  AST_T0_SPLIT: assert property (@(posedge clk) disable iff (!rst_n)
    porteAltSelect[pdem_pkg::PE_T0] && timerEv.t0Mode3 && timerEv.t0HiOvf && !timerEv.t0Ovf
    |=> !portePinOut[pdem_pkg::PE_T0])
    else $error("high byte overflow reached pin");
  AST_T1_SPLIT: assert property (@(posedge clk) disable iff (!rst_n)
    porteAltSelect[pdem_pkg::PE_T1] && timerEv.t1Mode3 && timerEv.t1HiOvf && !timerEv.t1Ovf
    |=> !portePinOut[pdem_pkg::PE_T1])
    else $error("timer 1 high byte overflow reached pin");
  AST_U0_IDLE: assert property (@(posedge clk) disable iff (!rst_n)
    porteAltSelect[pdem_pkg::PE_U0] && uart0.mode != pdem_pkg::UART_MODE_SYNC |=> portePinOut[pdem_pkg::PE_U0])
    else $error("uart0 pin not idle high");
  AST_U1_IDLE: assert property (@(posedge clk) disable iff (!rst_n)
    porteAltSelect[pdem_pkg::PE_U1] && uart1.mode != pdem_pkg::UART_MODE_SYNC |=> portePinOut[pdem_pkg::PE_U1])
    else $error("uart1 pin not high");
  AST_EXTINT_EDGE: assert property (@(posedge clk) disable iff (!rst_n)
    extInterruptSix |=> !extInterruptSix)
    else $error("interrupt six not a single pulse");
  AST_RELOAD_EN: assert property (@(posedge clk) disable iff (!rst_n)
    !$past(timer2ExtEnable) |-> !timer2Reload)
    else $error("reload without enable");
  AST_ADR8: assert property (@(posedge clk) disable iff (!rst_n)
    porteAltSelect[pdem_pkg::PE_ADR8] |=> portePinOut[pdem_pkg::PE_ADR8] == $past(waveformAddrBit8))
    else $error("address bit 8 not on pin");
  AST_DATA_SEL: assert property (@(posedge clk) disable iff (!rst_n)
    dataSel |=> portdPinOut == $past(ifaceDataOut))
    else $error("upper data not on port D");
  AST_STROBE_MODE: assert property (@(posedge clk) disable iff (!rst_n)
    interfaceConfigMode != pdem_pkg::IFMODE_SLAVE |=> !slaveReadStrobe && !slaveWriteStrobe)
    else $error("strobe outside slave mode");
  AST_READY_IN2: assert property (@(posedge clk) disable iff (!rst_n)
    rdySync[2] |=> waveReady[2])
    else $error("ready 2 lost");
  AST_RESET_IN: assert property (@(posedge clk)
    !rst_n |-> portePinOe_n == 8'hff && portdPinOe_n == 4'hf)
    else $error("pin driven in reset");

  COV_T0: cover property (@(posedge clk) disable iff (!rst_n) portePinOut[pdem_pkg::PE_T0] && porteAltSelect[0]);
  COV_EXTINT: cover property (@(posedge clk) disable iff (!rst_n) extInterruptSix);
  COV_RELOAD: cover property (@(posedge clk) disable iff (!rst_n) timer2Reload);
  COV_RD: cover property (@(posedge clk) disable iff (!rst_n) slaveReadStrobe);

endmodule : pdem_mux

// >>> hdl/pdem_pkg.sv
// Package for the port D / port E alternate function multiplexer
package pdem_pkg;

  // Interface mode field encodings
  localparam logic [1:0] IFMODE_PORTS = 2'h0; // Plain ports
  localparam logic [1:0] IFMODE_RSVD = 2'h1; // Reserved, treated as ports
  localparam logic [1:0] IFMODE_WAVE = 2'h2; // Waveform engine master
  localparam logic [1:0] IFMODE_SLAVE = 2'h3; // Slave FIFO

  // Port E alternate function bit positions
  localparam int PE_T0 = 0;
  localparam int PE_T1 = 1;
  localparam int PE_T2 = 2;
  localparam int PE_U0 = 3;
  localparam int PE_U1 = 4;
  localparam int PE_EXTINT = 5;
  localparam int PE_RELOAD = 6;
  localparam int PE_ADR8 = 7;

  // Polarity control bit positions
  localparam int POL_RD = 3;
  localparam int POL_WR = 2;

  // Reset values
  localparam logic [7:0] PORTE_SEL_RST = 8'h00;
  localparam logic [1:0] UART_MODE_SYNC = 2'h0;

  // Synchroniser depth for pin inputs
  localparam int SYNC_STAGES = 3;

  // Strobe mux state
  typedef enum logic [1:0] {
    PDEM_RDY_WAVE = 2'b00,
    PDEM_RDY_SLAVE = 2'b01,
    PDEM_RDY_IDLE = 2'b10
  } pdem_rdy_mode_t;

  // Internal events from the core side
  typedef struct packed {
    logic t0Ovf;      // Timer 0 (low byte in mode 3) overflow
    logic t0Mode3;    // Timer 0 split mode
    logic t0HiOvf;    // High byte overflow in split mode
    logic t1Ovf;
    logic t1Mode3;
    logic t1HiOvf;
    logic t2Ovf;
  } pdem_timer_ev_t;

  // UART sync data sources
  typedef struct packed {
    logic [1:0] mode;
    logic syncData;
  } pdem_uart_t;

endpackage : pdem_pkg

// >>> hdl/pdem_sync.sv
// Three-stage pin synchroniser with agreement qualified output
`timescale 1ns/100ps
module pdem_sync (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic pinIn,
  output logic levelOut
);

  logic [pdem_pkg::SYNC_STAGES-1:0] stage_q; // Shift chain, stage 0 only feeds stage 1

  // Shift the pin through the chain
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stage_q <= '0;
    end else begin
      stage_q <= {stage_q[pdem_pkg::SYNC_STAGES-2:0], pinIn};
    end
  end

  // Accept a change only when the last two stages agree
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      levelOut <= 1'b0;
    end else if (stage_q[1] == stage_q[2]) begin
      levelOut <= stage_q[2];
    end
  end

endmodule : pdem_sync

// >>> testbench/pdem_partner.sv
// Behavioural external master driving the ready / strobe pins
`timescale 1ns/100ps
module pdem_partner (
  input wire logic clk,
  input wire logic polRd,
  input wire logic polWr,
  input wire logic rdReq,
  input wire logic wrReq,
  output logic readyIn0,
  output logic readyIn1
);
  // Strobes move just after the edge; write yields to read, so one at a time
  // Unknown until the first edge, which falls inside reset
  always @(posedge clk) begin
    readyIn0 <= #1 rdReq ? polRd : !polRd;
    readyIn1 <= #1 (wrReq && !rdReq) ? polWr : !polWr;
  end
endmodule : pdem_partner

// >>> testbench/pdem_mux_tb.sv
// Self-checking bench for the port D / port E alternate function multiplexer
`timescale 1ns/100ps
module pdem_mux_tb;
  // Row: config, sources, then expected pin drive
  typedef struct packed {
    logic [1:0] md; logic ww; logic [3:0] pd, po, fd, fo; logic [7:0] sel, eo, ee; logic [6:0] ev;
    logic [2:0] u0, u1; logic a8; logic [7:0] xo, xn; logic [3:0] xd, xdn;
  } pdem_row_t;
  pdem_row_t rows [5] = '{
    '{2'h0, 1'h1, 4'h3, 4'hf, 4'hc, 4'hf, 8'h00, 8'ha5, 8'h0f, 7'h00, 3'h0, 3'h0, 1'h0, 8'ha5, 8'hf0, 4'h3, 4'h0},
    '{2'h2, 1'h0, 4'h5, 4'h0, 4'h6, 4'hf, 8'hff, 8'h00, 8'h00, 7'h00, 3'h0, 3'h0, 1'h0, 8'h00, 8'h60, 4'h5, 4'hf},
    '{2'h2, 1'h1, 4'h0, 4'h0, 4'ha, 4'hf, 8'hff, 8'hff, 8'hff, 7'h49, 3'h1, 3'h2, 1'h1, 8'h9f, 8'h60, 4'ha, 4'h0},
    '{2'h3, 1'h1, 4'h0, 4'h0, 4'h6, 4'h3, 8'hff, 8'h00, 8'h00, 7'h36, 3'h4, 3'h6, 1'h0, 8'h18, 8'h60, 4'h6, 4'hc},
    '{2'h1, 1'h1, 4'h9, 4'hf, 4'h3, 4'hf, 8'h18, 8'h00, 8'hff, 7'h00, 3'h1, 3'h1, 1'h0, 8'h18, 8'h00, 4'h9, 4'h0}};
  logic clk = 1'b0;
  logic rst_n = 1'b1;
  logic [1:0] mode = 2'h0;
  logic ww = 1'b0, t2En = 1'b0, a8 = 1'b0, readyPin2 = 1'b0, rdReq = 1'b0, wrReq = 1'b0;
  logic [7:0] sel = 8'h00, eOut = 8'h00, eOe = 8'h00, ePin = 8'h00;
  logic [3:0] pol = 4'h0, dOut = 4'h0, dOe = 4'h0, fOut = 4'h0, fOe = 4'h0, dPin = 4'h0;
  pdem_pkg::pdem_timer_ev_t ev = '0;
  pdem_pkg::pdem_uart_t u0 = '0, u1 = '0;
  logic [3:0] dPinOut, dPinOeN, dIn, fIn;
  logic [7:0] ePinOut, ePinOeN, eIn;
  logic extInt, reload, sRd, sWr, readyPin0, readyPin1;
  logic [2:0] wRdy;
  int n_errors = 0, tests_run = 0;
  // 250 MHz core clock
  always #2 clk = ~clk;
  pdem_partner u_pdem_partner (.clk(clk), .polRd(pol[3]), .polWr(pol[2]), .rdReq(rdReq), .wrReq(wrReq),
    .readyIn0(readyPin0), .readyIn1(readyPin1));
  pdem_mux u_pdem_mux (.clk(clk), .rst_n(rst_n), .interfaceConfigMode(mode), .endpointWordWide(ww),
    .porteAltSelect(sel), .fifoPinPolarity(pol), .timer2ExtEnable(t2En), .portdOut(dOut), .portdOe(dOe),
    .ifaceDataOut(fOut), .ifaceDataOe(fOe), .portdPinIn(dPin), .portdPinOut(dPinOut), .portdPinOe_n(dPinOeN),
    .portdIn(dIn), .ifaceDataIn(fIn), .porteOut(eOut), .porteOe(eOe), .portePinIn(ePin), .portePinOut(ePinOut),
    .portePinOe_n(ePinOeN), .porteIn(eIn), .timerEv(ev), .uart0(u0), .uart1(u1), .waveformAddrBit8(a8),
    .extInterruptSix(extInt), .timer2Reload(reload), .readyIn0(readyPin0), .readyIn1(readyPin1),
    .readyIn2(readyPin2),
    .waveReady(wRdy), .slaveReadStrobe(sRd), .slaveWriteStrobe(sWr));
  // Inputs move one fixed step after the rising edge
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // Counts edge pulses over a window longer than the sync latency
  task automatic cnt(input logic which, input logic [7:0] exp);
    logic [7:0] n;
    n = 8'h00;
    repeat (12) begin
      tick(1);
      if ((which ? reload : extInt) === 1'b1) n++;
    end
    chk(n, exp);
  endtask : cnt
  task automatic report_and_stop;
    $display("errors=%0d checks=%0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : report_and_stop
  // Hang guard, far beyond the few hundred cycles the tests need
  initial begin
    #20000;
    n_errors++;
    report_and_stop();
  end
  initial begin
    // A real falling edge, so the asynchronous reset branch runs
    #1 rst_n = 1'b0;
    tick(12);
    chk(ePinOeN, 8'hff);
    chk({dPinOeN, extInt, reload, sRd, sWr}, 8'hf0);
    rst_n = 1'b1;
    tick(2);
    chk({dPinOeN, ePinOeN[3:0]}, 8'hff);
    // Ordinary cases; masked compare skips pins that are released
    foreach (rows[i]) begin
      {mode, ww, dOut, dOe, fOut, fOe, sel, eOut, eOe} = {rows[i].md, rows[i].ww, rows[i].pd, rows[i].po,
        rows[i].fd, rows[i].fo, rows[i].sel, rows[i].eo, rows[i].ee};
      {ev, u0, u1, a8, dPin, ePin} = {rows[i].ev, rows[i].u0, rows[i].u1, rows[i].a8, rows[i].fd, rows[i].eo};
      tick(8);
      chk(ePinOeN, rows[i].xn);
      chk(ePinOut & ~rows[i].xn, rows[i].xo & ~rows[i].xn);
      chk({dPinOeN, dPinOut & ~rows[i].xdn}, {rows[i].xdn, rows[i].xd & ~rows[i].xdn});
      chk(eIn, rows[i].eo & ~rows[i].sel);
      chk({dIn, fIn}, (mode[1] && ww) ? {4'h0, rows[i].fd} : {rows[i].fd, 4'h0});
    end
    // Single-cycle overflow pulses stay one cycle wide
    sel = 8'h07;
    ev = pdem_pkg::pdem_timer_ev_t'(7'h49);
    tick(1);
    ev = '0;
    chk(ePinOut & 8'h07, 8'h07);
    tick(1);
    chk(ePinOut & 8'h07, 8'h00);
    // Input alternates: edge direction, enable and select gating
    ePin = 8'h00;
    sel = 8'h60;
    t2En = 1'b1;
    tick(8);
    ePin[5] = 1'b1;
    cnt(1'b0, 8'h01);
    ePin[5] = 1'b0;
    cnt(1'b0, 8'h00);
    ePin[6] = 1'b1;
    cnt(1'b1, 8'h00);
    ePin[6] = 1'b0;
    cnt(1'b1, 8'h01);
    t2En = 1'b0;
    ePin[6] = 1'b1;
    tick(8);
    ePin[6] = 1'b0;
    cnt(1'b1, 8'h00);
    sel = 8'h00;
    ePin[5] = 1'b1;
    cnt(1'b0, 8'h00);
    // Strobes at every polarity pair, then ready inputs in waveform mode
    for (int p = 0; p < 4; p++) begin
      pol = {p[1:0], 2'h0};
      readyPin2 = p[0];
      mode = pdem_pkg::IFMODE_SLAVE;
      rdReq = 1'b1;
      tick(9);
      chk({wRdy, sRd, sWr}, {readyPin2, 4'h2});
      rdReq = 1'b0;
      wrReq = 1'b1;
      tick(9);
      chk({wRdy, sRd, sWr}, {readyPin2, 4'h1});
      wrReq = 1'b0;
      tick(9);
      chk({wRdy, sRd, sWr}, {readyPin2, 4'h0});
      mode = pdem_pkg::IFMODE_WAVE;
      rdReq = 1'b1;
      tick(9);
      chk({wRdy, sRd, sWr}, {readyPin2, !pol[2], pol[3], 2'h0});
    end
    // Read request stays up across iterations so it never toggles in one step
    rdReq = 1'b0;
    tick(1);
    // Mid-run reset releases every pin at once, then drive resumes
    rst_n = 1'b0;
    tick(1);
    chk(ePinOeN, 8'hff);
    chk({dPinOeN, extInt, reload, sRd, sWr}, 8'hf0);
    rst_n = 1'b1;
    tick(2);
    chk({dPinOeN, ePinOeN[3:0]}, 8'h00);
    report_and_stop();
  end
endmodule : pdem_mux_tb
